// File: dph_pkg.sv
package dph_pkg;

    // register map, byte addresses
    localparam logic [7:0]  ADDR_IDENT       = 8'h00;
    localparam logic [7:0]  ADDR_HOLD_CTL    = 8'h04;
    localparam logic [7:0]  ADDR_PORT_STATUS = 8'h08;
    localparam logic [31:0] HOLD_CTL_RESET   = 32'h0000_0000;
    localparam logic [31:0] HOLD_CTL_MASK    = 32'hC0FB_8F07;

    // hold control field positions
    localparam int BIT_SLEEP_KEEP     = 0;
    localparam int BIT_DEEPSLEEP_KEEP = 1;
    localparam int BIT_STANDBY_KEEP   = 2;
    localparam int BIT_FREE_WDG       = 8;
    localparam int BIT_WINDOW_WDG     = 9;
    localparam int BIT_TIMER_A        = 10;
    localparam int BIT_TIMER_B        = 11;
    localparam int BIT_TWOWIRE0       = 15;
    localparam int BIT_TWOWIRE1       = 16;
    localparam int BIT_TIMER_E        = 17;
    localparam int BIT_TIMER_C        = 19;
    localparam int BIT_TIMER_D        = 20;
    localparam int BIT_MULTIFUNC      = 21;
    localparam int BIT_CANBUS0        = 22;
    localparam int BIT_CANBUS1        = 23;
    localparam int BIT_TIMER_G        = 30;
    localparam int BIT_TIMER_F        = 31;

    // port switching sequence
    localparam int          LINE_RESET_MIN   = 50;
    localparam logic [15:0] SEQ_JTAG_TO_SW   = 16'hE79E;
    localparam logic [15:0] SEQ_SW_TO_JTAG   = 16'hE73C;

    // tap chain
    localparam int          SCAN_IR_BITS     = 5;
    localparam int          CORE_IR_BITS     = 4;
    localparam logic [4:0]  SCAN_IR_BYPASS   = 5'h1F;
    localparam logic [4:0]  SCAN_IR_IDENT    = 5'h01;
    localparam logic [3:0]  CORE_IR_IDENT    = 4'hE;
    localparam logic [3:0]  CORE_IR_BYPASS   = 4'hF;

    // debug rom table base
    localparam logic [31:0] ROM_TABLE_BASE   = 32'hE00F_F000;

    typedef enum logic [1:0] {
        DPH_PORT_JTAG = 2'h0,
        DPH_PORT_SW   = 2'h1,
        DPH_PORT_NONE = 2'h3
    } dph_port_t;

    typedef enum logic [3:0] {
        TS_RESET = 4'h0, TS_IDLE  = 4'h1, TS_SDR_SEL = 4'h3, TS_CDR = 4'h2,
        TS_SDR   = 4'h6, TS_E1DR  = 4'h7, TS_PDR     = 4'h5, TS_E2DR = 4'h4,
        TS_UDR   = 4'hC, TS_SIR_SEL = 4'hD, TS_CIR   = 4'hF, TS_SIR  = 4'hE,
        TS_E1IR  = 4'hA, TS_PIR   = 4'hB, TS_E2IR    = 4'h9, TS_UIR  = 4'h8
    } dph_tap_t;

    typedef struct packed {
        logic sleep_clock_keep;
        logic deepsleep_clock_keep;
        logic standby_clock_keep;
        logic standby_exit_reset;
    } dph_power_t;

    typedef struct packed {
        logic [6:0] timer_freeze;
        logic [1:0] twowire_timeout_freeze;
        logic       window_watchdog_freeze;
        logic       free_watchdog_freeze;
        logic [1:0] canbus_freeze;
        logic       multifunc_comm_freeze;
    } dph_freeze_t;

    typedef struct packed {
        logic test_data_out;
        logic test_data_out_oe;
        logic swdio_out;
        logic swdio_oe;
    } dph_pin_out_t;

endpackage : dph_pkg

// File: dph_debug_port.sv
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module dph_debug_port #(
    parameter logic [31:0] IDENT_VALUE   = 32'h1234_5001, // arbitrary value
    parameter logic [31:0] JEDEC_VALUE   = 32'h0000_0ABC, // arbitrary value
    parameter int          LINE_RESET    = dph_pkg::LINE_RESET_MIN
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic [7:0]            reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_write,
    input  wire logic                  reg_read,
    output logic [31:0]                reg_rdata,
    input  wire logic                  system_reset,
    input  wire logic                  debug_halt_request,
    output logic                       core_halted,
    input  wire logic                  test_reset_pin_used,
    input  wire logic                  debug_port_disable,
    input  wire logic                  test_clock_pin,
    input  wire logic                  test_mode_select_pin,
    input  wire logic                  test_data_in_pin,
    input  wire logic                  test_reset_n_pin,
    output dph_pkg::dph_pin_out_t      pin_out,
    output dph_pkg::dph_port_t         active_port,
    output logic [4:0]                 pin_debug_owned,
    output dph_pkg::dph_power_t        power_keep,
    output dph_pkg::dph_freeze_t       freeze,
    input  wire logic                  rom_read,
    input  wire logic [31:0]           rom_addr,
    output logic [31:0]                rom_rdata
);
    import dph_pkg::*;

    // rst is power-on reset; system_reset touches only the halt state (halt_pending, core_halted)
    logic [1:0]  tck_sync;
    logic [1:0]  tms_sync;
    logic [1:0]  tdi_sync;
    logic [1:0]  trst_sync;
    logic        tck_prev;
    logic        tck_rise;
    logic        tck_fall;
    logic        trst_n_int;

    always_ff @(posedge clk) begin
        if (rst) begin
            tck_sync  <= 2'h0;
            tms_sync  <= 2'h3;
            tdi_sync  <= 2'h0;
            trst_sync <= 2'h3;
            tck_prev  <= 1'b0;
        end else begin
            tck_sync  <= {tck_sync[0], test_clock_pin};
            tms_sync  <= {tms_sync[0], test_mode_select_pin};
            tdi_sync  <= {tdi_sync[0], test_data_in_pin};
            trst_sync <= {trst_sync[0], test_reset_n_pin};
            tck_prev  <= tck_sync[1];
        end
    end

    // edges land about three clocks late, so the link clock must stay slow
    assign tck_rise = tck_sync[1] & ~tck_prev;
    assign tck_fall = ~tck_sync[1] & tck_prev;
    // shared clock and mode pins serve both protocols
    // unused reset pin reads as inactive
    assign trst_n_int = test_reset_pin_used ? trst_sync[1] : 1'b1;

    // switch sequence detection: count of high cycles, then 16-bit pattern
    typedef enum logic [1:0] {
        SW_HUNT = 2'h0, SW_PATTERN = 2'h1, SW_TRAIL = 2'h3
    } dph_sw_t;

    dph_sw_t     sw_state;
    logic [6:0]  high_count;
    logic [15:0] pattern;
    logic [4:0]  pattern_bits;
    logic        to_sw;
    dph_port_t   port;
    logic [15:0] pattern_next;

    assign pattern_next = {tms_sync[1], pattern[15:1]};

    always_ff @(posedge clk) begin
        if (rst) begin
            sw_state     <= SW_HUNT;
            high_count   <= 7'h00;
            pattern      <= 16'h0000;
            pattern_bits <= 5'h00;
            to_sw        <= 1'b0;
            port         <= DPH_PORT_JTAG;
        end else if (tck_rise) begin
            unique case (sw_state)
                SW_HUNT: begin
                    if (tms_sync[1]) begin
                        if (high_count != 7'h7F)
                            high_count <= high_count + 7'h01;
                    end else if (int'(high_count) >= LINE_RESET) begin
                        sw_state     <= SW_PATTERN;
                        pattern      <= 16'h0000;
                        pattern_bits <= 5'h01;
                        high_count   <= 7'h00;
                    end else begin
                        high_count <= 7'h00;
                    end
                end
                SW_PATTERN: begin
                    // lsb arrives first, so shift in from the top
                    pattern      <= pattern_next;
                    pattern_bits <= pattern_bits + 5'h01;
                    if (pattern_bits == 5'h0F) begin
                        if (pattern_next == SEQ_JTAG_TO_SW
                                && port == DPH_PORT_JTAG) begin
                            to_sw    <= 1'b1;
                            sw_state <= SW_TRAIL;
                        end else if (pattern_next == SEQ_SW_TO_JTAG
                                && port == DPH_PORT_SW) begin
                            to_sw    <= 1'b0;
                            sw_state <= SW_TRAIL;
                        end else begin
                            sw_state <= SW_HUNT;
                        end
                        high_count <= 7'h00;
                    end
                end
                SW_TRAIL: begin
                    if (!tms_sync[1]) begin
                        sw_state   <= SW_HUNT;
                        high_count <= 7'h00;
                    end else if (int'(high_count) + 1 >= LINE_RESET) begin
                        // saturated count lets this trailing run open the next sequence
                        port       <= to_sw ? DPH_PORT_SW : DPH_PORT_JTAG;
                        sw_state   <= SW_HUNT;
                        high_count <= 7'h7F;
                    end else begin
                        high_count <= high_count + 7'h01;
                    end
                end
                default: sw_state <= SW_HUNT;
            endcase
        end
    end

    assign active_port = debug_port_disable ? DPH_PORT_NONE : port;

    // pin ownership: {reset, data_out, data_in, mode, clock}
    always_comb begin
        unique case (active_port)
            DPH_PORT_JTAG: pin_debug_owned = test_reset_pin_used ? 5'h1F : 5'h0F;
            DPH_PORT_SW:   pin_debug_owned = 5'h03;
            default:       pin_debug_owned = 5'h00;
        endcase
    end

    // tap controller; only the test reset touches it besides power-on
    dph_tap_t    tap;
    logic [4:0]  scan_ir;
    logic [3:0]  core_ir;
    logic [8:0]  ir_shift;
    logic [32:0] dr_shift;
    logic        tdo_q;

    function automatic dph_tap_t tap_next(input dph_tap_t s, input logic tms);
        unique case (s)
            TS_RESET:   tap_next = tms ? TS_RESET   : TS_IDLE;
            TS_IDLE:    tap_next = tms ? TS_SDR_SEL : TS_IDLE;
            TS_SDR_SEL: tap_next = tms ? TS_SIR_SEL : TS_CDR;
            TS_CDR:     tap_next = tms ? TS_E1DR    : TS_SDR;
            TS_SDR:     tap_next = tms ? TS_E1DR    : TS_SDR;
            TS_E1DR:    tap_next = tms ? TS_UDR     : TS_PDR;
            TS_PDR:     tap_next = tms ? TS_E2DR    : TS_PDR;
            TS_E2DR:    tap_next = tms ? TS_UDR     : TS_SDR;
            TS_UDR:     tap_next = tms ? TS_SDR_SEL : TS_IDLE;
            TS_SIR_SEL: tap_next = tms ? TS_RESET   : TS_CIR;
            TS_CIR:     tap_next = tms ? TS_E1IR    : TS_SIR;
            TS_SIR:     tap_next = tms ? TS_E1IR    : TS_SIR;
            TS_E1IR:    tap_next = tms ? TS_UIR     : TS_PIR;
            TS_PIR:     tap_next = tms ? TS_E2IR    : TS_PIR;
            TS_E2IR:    tap_next = tms ? TS_UIR     : TS_SIR;
            TS_UIR:     tap_next = tms ? TS_SDR_SEL : TS_IDLE;
        endcase
    endfunction : tap_next

    logic jtag_live;
    logic scan_bypass;
    logic [5:0] dr_len;

    assign jtag_live   = (active_port == DPH_PORT_JTAG);
    assign scan_bypass = (scan_ir != SCAN_IR_IDENT);
    // one extra bypass bit ahead of the core register
    always_comb begin
        if (!scan_bypass)
            dr_len = 6'h21;
        else if (core_ir == CORE_IR_IDENT)
            dr_len = 6'h21;
        else
            dr_len = 6'h02;
    end

    always_ff @(posedge clk) begin
        if (rst || !trst_n_int) begin
            tap <= TS_RESET;
        end else if (jtag_live && tck_rise) begin
            tap <= tap_next(tap, tms_sync[1]);
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !trst_n_int || (tap == TS_RESET)) begin
            scan_ir  <= SCAN_IR_IDENT;
            core_ir  <= CORE_IR_IDENT;
            ir_shift <= 9'h000;
            dr_shift <= 33'h0;
        end else if (jtag_live && tck_rise) begin
            unique case (tap)
                TS_CIR: ir_shift <= {4'h0, 5'h01};
                // scan bits enter first and settle at the data out end
                TS_SIR: ir_shift <= {tdi_sync[1], ir_shift[8:1]};
                TS_UIR: begin
                    scan_ir <= ir_shift[4:0];
                    core_ir <= ir_shift[8:5];
                end
                TS_CDR: begin
                    if (!scan_bypass)
                        dr_shift <= {1'b0, IDENT_VALUE};
                    else if (core_ir == CORE_IR_IDENT)
                        dr_shift <= {IDENT_VALUE, 1'b0};
                    else
                        dr_shift <= 33'h0;
                end
                TS_SDR: begin
                    dr_shift <= dr_shift >> 1;
                    dr_shift[dr_len - 6'd1] <= tdi_sync[1];
                end
                default: ;
            endcase
        end
    end

    // data out changes on the falling edge of the test clock
    always_ff @(posedge clk) begin
        if (rst) begin
            tdo_q <= 1'b0;
        end else if (tck_fall) begin
            unique case (tap)
                TS_SDR:  tdo_q <= dr_shift[0];
                TS_SIR:  tdo_q <= ir_shift[0];
                default: tdo_q <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_out <= '0;
        end else begin
            pin_out.test_data_out    <= tdo_q;
            pin_out.test_data_out_oe <= jtag_live && (tap == TS_SDR || tap == TS_SIR);
            // no serial wire engine here, so the shared data pin stays released
            pin_out.swdio_out        <= 1'b0;
            pin_out.swdio_oe         <= 1'b0;
        end
    end

    // registers; power-on reset only
    logic [31:0] hold_ctl;

    always_ff @(posedge clk) begin
        if (rst) begin
            hold_ctl <= HOLD_CTL_RESET;
        end else if (reg_write && reg_addr == ADDR_HOLD_CTL) begin
            hold_ctl <= reg_wdata & HOLD_CTL_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_read) begin
            unique case (reg_addr)
                ADDR_IDENT:       reg_rdata <= IDENT_VALUE;
                ADDR_HOLD_CTL:    reg_rdata <= hold_ctl;
                ADDR_PORT_STATUS: reg_rdata <= {23'h0, pin_debug_owned, tap == TS_RESET,
                                                1'b0, active_port};
                default:          reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // halt-after-reset: request caught under system reset halts on release
    logic halt_pending;

    always_ff @(posedge clk) begin
        if (rst) begin
            halt_pending <= 1'b0;
            core_halted  <= 1'b0;
        end else if (system_reset) begin
            halt_pending <= halt_pending | debug_halt_request;
            core_halted  <= 1'b0;
        end else begin
            halt_pending <= 1'b0;
            core_halted  <= debug_halt_request | halt_pending;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rom_rdata <= 32'h0000_0000;
        end else if (rom_read && rom_addr == ROM_TABLE_BASE) begin
            rom_rdata <= JEDEC_VALUE;
        end else begin
            rom_rdata <= 32'h0000_0000;
        end
    end

    // every freeze is the halt gating one hold bit
    function automatic logic held(input int pos);
        held = core_halted & hold_ctl[pos];
    endfunction : held

    // power keep levels follow the bits directly; counter freezes follow them gated by the halt
    always_comb begin
        power_keep.standby_clock_keep   = hold_ctl[BIT_STANDBY_KEEP];
        power_keep.standby_exit_reset   = hold_ctl[BIT_STANDBY_KEEP];
        power_keep.deepsleep_clock_keep = hold_ctl[BIT_DEEPSLEEP_KEEP];
        power_keep.sleep_clock_keep     = hold_ctl[BIT_SLEEP_KEEP];
        // combinational so the freeze lifts the cycle the halt or bit drops
        freeze.timer_freeze[0]           = held(BIT_TIMER_A);
        freeze.timer_freeze[1]           = held(BIT_TIMER_B);
        freeze.timer_freeze[2]           = held(BIT_TIMER_C);
        freeze.timer_freeze[3]           = held(BIT_TIMER_D);
        freeze.timer_freeze[4]           = held(BIT_TIMER_E);
        freeze.timer_freeze[5]           = held(BIT_TIMER_F);
        freeze.timer_freeze[6]           = held(BIT_TIMER_G);
        freeze.twowire_timeout_freeze[0] = held(BIT_TWOWIRE0);
        freeze.twowire_timeout_freeze[1] = held(BIT_TWOWIRE1);
        freeze.window_watchdog_freeze    = held(BIT_WINDOW_WDG);
        freeze.free_watchdog_freeze      = held(BIT_FREE_WDG);
        freeze.canbus_freeze[0]          = held(BIT_CANBUS0);
        freeze.canbus_freeze[1]          = held(BIT_CANBUS1);
        freeze.multifunc_comm_freeze     = held(BIT_MULTIFUNC);
    end

endmodule : dph_debug_port
`default_nettype wire

// File: dph_probe.sv
`timescale 1ns/1ps
`default_nettype none
// external debug probe; the test clock stands low between frames
module dph_probe (
    input  wire logic tdo_pin,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      trst_n
);
    logic [127:0] got;

    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trst_n = 1'b1;
    end

    // one 80 ns test clock; data out sampled mid high phase, after the late update lands
    // and before the state change from this rise can drop the output enable
    task cyc(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #40 tck = 1'b1;
        #20 q = tdo_pin;
        #20 tck = 1'b0;
    endtask : cyc

    task line_high(input int n);
        logic q;
        repeat (n) cyc(1'b1, 1'b0, q);
    endtask : line_high

    // high run, pattern lsb first, high run
    task switch_seq(input logic [15:0] s, input int n);
        logic q;
        line_high(n);
        for (int i = 0; i < 16; i++) cyc(s[i], 1'b0, q);
        line_high(n);
    endtask : switch_seq

    task to_shift(input logic ir);
        logic q;
        cyc(1'b0, 1'b0, q);
        cyc(1'b1, 1'b0, q);
        if (ir) cyc(1'b1, 1'b0, q);
        cyc(1'b0, 1'b0, q);
        cyc(1'b0, 1'b0, q);
    endtask : to_shift

    // shifts n bits lsb first, leaves through update to idle
    task shift(input int n, input logic [127:0] din);
        logic q;
        for (int i = 0; i < n; i++) begin
            cyc(i == n - 1, din[i], q);
            got[i] = q;
        end
        cyc(1'b1, 1'b0, q);
        cyc(1'b0, 1'b0, q);
    endtask : shift
endmodule : dph_probe
`default_nettype wire

// File: dph_debug_port_props.sv
`timescale 1ns/1ps
`default_nettype none
module dph_debug_port_props
    import dph_pkg::*;
#(
    parameter logic [31:0] IDENT_VALUE = 32'h0000_0001,
    parameter logic [31:0] JEDEC_VALUE = 32'h0000_0002
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic        system_reset,
    input wire logic        debug_halt_request,
    input wire logic        core_halted,
    input wire logic        test_reset_pin_used,
    input wire dph_port_t   active_port,
    input wire logic [4:0]  pin_debug_owned,
    input wire dph_power_t  power_keep,
    input wire dph_freeze_t freeze,
    input wire logic        rom_read,
    input wire logic [31:0] rom_addr,
    input wire logic [31:0] rom_rdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [31:0] wd_q;
    logic        hold_wr;
    assign hold_wr = reg_write && reg_addr == ADDR_HOLD_CTL;
    always_ff @(posedge clk) wd_q <= reg_wdata;

    chk_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    chk_ident_read: assert property (reg_read && reg_addr == ADDR_IDENT |=>
        reg_rdata == IDENT_VALUE) else $error("identification value wrong");
    chk_unmapped_zero: assert property (reg_read && reg_addr > ADDR_PORT_STATUS |=>
        reg_rdata == 32'h0) else $error("unmapped read not zero");
    chk_hold_readback: assert property (hold_wr ##1 reg_read && reg_addr == ADDR_HOLD_CTL |=>
        reg_rdata == ($past(reg_wdata, 2) & HOLD_CTL_MASK)) else $error("hold readback wrong");
    chk_power_map: assert property (hold_wr |=> power_keep[3:1] ==
        {wd_q[BIT_SLEEP_KEEP], wd_q[BIT_DEEPSLEEP_KEEP], wd_q[BIT_STANDBY_KEEP]})
        else $error("power keep bits wrong");
    chk_sysrst_keeps: assert property (system_reset && !reg_write |=>
        $stable(power_keep[3:1])) else $error("system reset changed hold bits");
    chk_free_running: assert property (!core_halted && !$past(core_halted) |->
        freeze == '0) else $error("freeze without halt");
    chk_halt_release: assert property ($fell(system_reset) && debug_halt_request |->
        ##[0:3] core_halted) else $error("no halt after system reset");
    chk_rom_ident: assert property (rom_read && rom_addr == ROM_TABLE_BASE |=>
        rom_rdata == JEDEC_VALUE) else $error("rom table id wrong");
    chk_sw_pins: assert property (active_port == DPH_PORT_SW && $stable(active_port) |->
        pin_debug_owned == 5'h03) else $error("serial wire pin ownership wrong");
    chk_none_pins: assert property (active_port == DPH_PORT_NONE && $stable(active_port) |->
        pin_debug_owned == 5'h00) else $error("released pins still owned");
    chk_jtag_pins: assert property (active_port == DPH_PORT_JTAG && $stable(active_port)
        && $stable(test_reset_pin_used) |-> pin_debug_owned == {test_reset_pin_used, 4'hF})
        else $error("jtag pin ownership wrong");
endmodule : dph_debug_port_props

bind dph_debug_port dph_debug_port_props #(.IDENT_VALUE(IDENT_VALUE), .JEDEC_VALUE(JEDEC_VALUE))
    u_props (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .system_reset(system_reset), .debug_halt_request(debug_halt_request),
    .core_halted(core_halted), .test_reset_pin_used(test_reset_pin_used),
    .active_port(active_port), .pin_debug_owned(pin_debug_owned), .power_keep(power_keep),
    .freeze(freeze), .rom_read(rom_read), .rom_addr(rom_addr), .rom_rdata(rom_rdata));
`default_nettype wire

// File: dph_debug_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dph_debug_port_bench;
    import dph_pkg::*;
    localparam logic [31:0] IDV = 32'h5A5A_0001; // arbitrary value
    localparam logic [31:0] JDV = 32'h0000_0C3D; // arbitrary value
    logic clk = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, system_reset = 1'b0;
    logic debug_halt_request = 1'b0, test_reset_pin_used = 1'b1, debug_port_disable = 1'b0;
    logic rom_read = 1'b0, core_halted, tck, tms, tdi, trst_n;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, rom_addr = 32'h0, reg_rdata, rom_rdata, v;
    logic [4:0]  pin_debug_owned;
    dph_pin_out_t pin_out;
    dph_port_t    active_port;
    dph_power_t   power_keep;
    dph_freeze_t  freeze;
    int failures = 0, checked = 0;
    int pos[14] = '{BIT_MULTIFUNC, BIT_CANBUS0, BIT_CANBUS1, BIT_FREE_WDG, BIT_WINDOW_WDG,
        BIT_TWOWIRE0, BIT_TWOWIRE1, BIT_TIMER_A, BIT_TIMER_B, BIT_TIMER_C, BIT_TIMER_D,
        BIT_TIMER_E, BIT_TIMER_F, BIT_TIMER_G};

    always #5 clk = ~clk;

    // short line reset count keeps the run brief
    dph_debug_port #(.IDENT_VALUE(IDV), .JEDEC_VALUE(JDV), .LINE_RESET(8)) DUT (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .system_reset(system_reset), .debug_halt_request(debug_halt_request),
        .core_halted(core_halted), .test_reset_pin_used(test_reset_pin_used),
        .debug_port_disable(debug_port_disable), .test_clock_pin(tck),
        .test_mode_select_pin(tms), .test_data_in_pin(tdi), .test_reset_n_pin(trst_n),
        .pin_out(pin_out), .active_port(active_port), .pin_debug_owned(pin_debug_owned),
        .power_keep(power_keep), .freeze(freeze), .rom_read(rom_read),
        .rom_addr(rom_addr), .rom_rdata(rom_rdata));

    // pull-up assumed on the data out pin while it is released
    dph_probe probe (.tdo_pin(pin_out.test_data_out_oe ? pin_out.test_data_out : 1'b1),
        .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n));

    task close_out;
        if (failures == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // called just after a rising edge; a back-to-back follower keeps the strobe high for its own cycle
    task wr(input logic [7:0] a, input logic [31:0] d);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, output logic [31:0] d);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task wait_for(input bit on_port, input logic [1:0] val);
        int n;
        for (n = 0; n < 400 && (on_port ? active_port : {1'b0, core_halted}) !== val; n++)
            @(posedge clk);
        if (n == 400) begin
            failures++;
            $display("CHECK FAILED at %0t: wait ran out", $time);
            close_out();
        end
        @(posedge clk);
    endtask : wait_for

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(ADDR_IDENT, v); check(v, IDV);
        rd(ADDR_HOLD_CTL, v); check(v, HOLD_CTL_RESET);
        rd(8'h10, v); check(v, 32'h0);
        rd(ADDR_PORT_STATUS, v); check({v[8:3], v[1:0]}, {5'h1F, 1'b1, DPH_PORT_JTAG});
        wr(ADDR_IDENT, 32'hFFFF_FFFF);
        rd(ADDR_IDENT, v); check(v, IDV);
        wr(ADDR_HOLD_CTL, 32'hFFFF_FFFF);
        rd(ADDR_HOLD_CTL, v); check(v, HOLD_CTL_MASK);
        check(freeze, '0);
        for (int j = 0; j < 3; j++) begin
            wr(ADDR_HOLD_CTL, 32'h1 << j);
            #1 check(power_keep[3:1], 3'b100 >> j);
        end
        debug_halt_request <= 1'b1;
        wait_for(1'b0, 2'b01);
        for (int k = 0; k < 14; k++) begin
            wr(ADDR_HOLD_CTL, 32'h1 << pos[k]);
            #1 check(freeze, 14'h1 << k);
        end
        wr(ADDR_HOLD_CTL, 32'h0);
        #1 check(freeze, '0);
        wr(ADDR_HOLD_CTL, 32'h0000_0400);
        debug_halt_request <= 1'b0;
        wait_for(1'b0, 2'b00);
        check(freeze, '0);
        // halt asked while the system is held in reset
        system_reset <= 1'b1;
        debug_halt_request <= 1'b1;
        repeat (4) @(posedge clk);
        rd(ADDR_HOLD_CTL, v); check(v, 32'h0000_0400);
        @(posedge clk);
        system_reset <= 1'b0;
        wait_for(1'b0, 2'b01);
        check(core_halted, 1'b1);
        debug_halt_request <= 1'b0;
        rom_read <= 1'b1;
        rom_addr <= ROM_TABLE_BASE;
        @(posedge clk);
        rom_read <= 1'b0;
        #1 check(rom_rdata, JDV);
        probe.to_shift(1'b0);
        probe.shift(32, '0);
        check(probe.got[31:0], IDV);
        probe.to_shift(1'b1);
        probe.shift(9, {119'h0, CORE_IR_IDENT, 5'h1F});
        probe.to_shift(1'b0);
        probe.shift(80, 128'h1 << 40);
        check(probe.got[73:72], 2'b10);
        check(probe.got[32:1], IDV);
        probe.switch_seq(SEQ_JTAG_TO_SW, 8);
        wait_for(1'b1, DPH_PORT_SW);
        check(pin_debug_owned, 5'h03);
        probe.switch_seq(SEQ_SW_TO_JTAG, 8);
        wait_for(1'b1, DPH_PORT_JTAG);
        check(pin_debug_owned, 5'h1F);
        test_reset_pin_used <= 1'b0;
        repeat (3) @(posedge clk);
        check(pin_debug_owned, 5'h0F);
        probe.to_shift(1'b0);
        probe.trst_n = 1'b0;
        repeat (10) @(posedge clk);
        rd(ADDR_PORT_STATUS, v); check(v[3], 1'b0);
        test_reset_pin_used <= 1'b1;
        repeat (10) @(posedge clk);
        rd(ADDR_PORT_STATUS, v); check(v[3], 1'b1);
        rd(ADDR_HOLD_CTL, v); check(v, 32'h0000_0400);
        probe.trst_n = 1'b1;
        debug_port_disable <= 1'b1;
        wait_for(1'b1, DPH_PORT_NONE);
        check(pin_debug_owned, 5'h00);
        close_out();
    end
endmodule : dph_debug_port_bench
`default_nettype wire
